// ===== bmsc_handler.sv
`timescale 1ns/1ps
// Overview of operation
// - Boot pin high at release: flash start
// - Boot pin low at release: boot ROM
// - Mode latched on reset falling transition (release)
// - All interrupts held off in boot mode
// - Third byte command; 0x20 means sum
// - Receive error: ack low nibble 8
// - Error ack upper nibble from previous command
// - Clocked I/O mode skips error check
// - Valid command echoed, routine entered
// - Unknown command: ack low nibble 1
// - Sum sent upper byte then lower byte
// - Host checksum: two's complement byte sum
// - Byte after sum exchange is next command
// - 0x30 requests product information, echoed
// - Bytes five to eight: software identifier
// - Block count sent as fixed two bytes
// - Group info from byte 57 onward
// - Groups in increasing block size, nine bytes
// - Info ends with two's complement checksum
// - Byte ninety-four is next command
module bmsc_handler
  import bmsc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // Boot select pin (port_h_bit_zero)
  input  wire logic        port_h_bit_zero_i,
  // Mode outputs
  output logic             boot_from_rom_o,
  output logic             irq_disable_o,
  // Serial receive stream
  input  wire logic        rx_valid_i,
  input  wire logic [7:0]  rx_data_i,
  input  wire logic        rx_error_i,
  input  wire logic        clocked_io_mode_i,
  // Serial transmit stream
  output logic             tx_valid_o,
  output logic [7:0]       tx_data_o,
  input  wire logic        tx_ready_i,
  // Flash data and identifier
  input  wire logic [15:0] flash_sum_i,
  input  wire logic [31:0] sw_id_i,
  input  wire logic [71:0] grp_info_i [INFO_GRP_NUM],
  // Checksum mismatch reported by host
  output logic             csum_bad_o
);

  // ==========================================================
  // Declarations
  // ==========================================================
  logic        pin_meta;       // First synchroniser stage
  logic        pin_sync;       // Second synchroniser stage
  logic        rst_q;          // Reset seen last cycle
  bmsc_state_t state;          // Handler state
  bmsc_state_t next_state;     // Next handler state
  logic [3:0]  prev_hi;        // Upper nibble of last command
  logic [7:0]  ack_byte;       // Pending acknowledge
  logic [7:0]  cmd;            // Accepted command
  logic [6:0]  idx;            // Response byte index
  logic [7:0]  csum;           // Running response sum
  logic [7:0]  info_byte;      // Current info byte
  logic        tx_fire;        // Byte leaves this cycle
  logic        rx_bad;         // Receive error counted
  logic [6:0]  grp_off;        // Index inside group table
  logic [1:0]  grp_sel;        // Group being sent
  logic [6:0]  grp_pos;        // Byte inside that group

  // Two's complement checksum step
  function automatic logic [7:0] csum_neg(input logic [7:0] s);
    csum_neg = 8'(~s + 8'h01);
  endfunction

  // Top bit of byte n, counted down from bit top
  function automatic logic [7:0] byte_top(input logic [7:0] top,
                                          input logic [6:0] n);
    byte_top = 8'(top - 8'(n) * 8'h08);
  endfunction

  // ==========================================================
  // Boot pin sampling
  // ==========================================================
  // Two-stage synchroniser for the pin
  always_ff @(posedge clk_i) begin
    pin_meta <= port_h_bit_zero_i;
    pin_sync <= pin_meta;
  end

  // Remember reset to catch its release
  always_ff @(posedge clk_i) begin
    rst_q <= reset_i;
  end

  // Mode caught at reset release
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      boot_from_rom_o <= 1'b0;
    end else if (rst_q) begin
      boot_from_rom_o <= ~pin_sync;
    end
  end

  // Interrupts blocked while boot ROM runs
  assign irq_disable_o = boot_from_rom_o;

  // ==========================================================
  // Command handling
  // ==========================================================
  assign tx_fire = tx_valid_o & tx_ready_i;
  assign rx_bad  = rx_error_i & ~clocked_io_mode_i;

  // Info byte selector
  always_comb begin
    info_byte = 8'h00;
    // Position inside the block group table
    grp_off   = 7'(idx - 7'(INFO_GRP_POS));
    grp_sel   = 2'(grp_off / 7'(INFO_GRP_LEN));
    grp_pos   = 7'(grp_off % 7'(INFO_GRP_LEN));
    if (idx < 7'(INFO_ID_LEN)) begin
      info_byte = sw_id_i[byte_top(8'h1f, idx) -: 8];
    end else if (idx == 7'(INFO_CNT_POS)) begin
      info_byte = BLK_COUNT_LO;
    end else if (idx == 7'(INFO_CNT_POS + 1)) begin
      info_byte = BLK_COUNT_HI;
    end else if (idx >= 7'(INFO_GRP_POS) &&
                 idx < 7'(INFO_LEN)) begin
      // Groups by increasing size, nine bytes each
      info_byte = grp_info_i[grp_sel][byte_top(8'h47, grp_pos) -: 8];
    end else if (idx == 7'(INFO_LEN)) begin
      info_byte = csum_neg(csum);
    end
  end

  // Next state
  always_comb begin
    next_state = state;
    unique case (state)
      BMSC_WAIT_CMD: begin
        if (rx_valid_i) begin
          next_state = BMSC_SEND_ACK;
        end
      end
      BMSC_SEND_ACK: begin
        if (tx_fire) begin
          if (cmd == CMD_SUM) begin
            next_state = BMSC_SEND_SUM;
          end else if (cmd == CMD_INFO) begin
            next_state = BMSC_SEND_INFO;
          end else begin
            next_state = BMSC_WAIT_CMD;
          end
        end
      end
      BMSC_SEND_SUM: begin
        if (tx_fire && idx == 7'h01) begin
          next_state = BMSC_WAIT_CSUM;
        end
      end
      BMSC_WAIT_CSUM: begin
        if (rx_valid_i) begin
          next_state = BMSC_WAIT_CMD;
        end
      end
      BMSC_SEND_INFO: begin
        if (tx_fire && idx == 7'(INFO_LEN)) begin
          next_state = BMSC_WAIT_CMD;
        end
      end
      default: next_state = BMSC_WAIT_CMD;
    endcase
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state <= BMSC_WAIT_CMD;
    end else begin
      state <= next_state;
    end
  end

  // Command capture and acknowledge build
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cmd      <= 8'h00;
      ack_byte <= 8'h00;
      prev_hi  <= PREV_CMD_RST;
    end else if (state == BMSC_WAIT_CMD && rx_valid_i) begin
      if (rx_bad) begin
        cmd      <= 8'h00; // Forces return to wait
        ack_byte <= {prev_hi, 4'h0} | 8'(1 << ACK_RXERR_BIT);
      end else if (rx_data_i == CMD_SUM || rx_data_i == CMD_INFO) begin
        cmd      <= rx_data_i;
        ack_byte <= rx_data_i;
        prev_hi  <= rx_data_i[7:4];
      end else begin
        cmd      <= rx_data_i;
        ack_byte <= {prev_hi, 4'h0} | 8'(1 << ACK_BADCMD_BIT);
        prev_hi  <= rx_data_i[7:4];
      end
    end
  end

  // Response index and running sum
  always_ff @(posedge clk_i) begin
    if (reset_i || state == BMSC_SEND_ACK || state == BMSC_WAIT_CMD) begin
      idx  <= IDX_RST;
      csum <= 8'h00;
    end else if (tx_fire) begin
      idx  <= 7'(idx + 7'h01);
      csum <= 8'(csum + tx_data_o);
    end
  end

  // Host checksum compare on the sum exchange
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      csum_bad_o <= 1'b0;
    end else if (state == BMSC_WAIT_CSUM && rx_valid_i) begin
      csum_bad_o <= (rx_data_i != csum_neg(csum));
    end
  end

  // ==========================================================
  // Transmit output
  // ==========================================================
  assign tx_valid_o = (state == BMSC_SEND_ACK) ||
                      (state == BMSC_SEND_SUM) ||
                      (state == BMSC_SEND_INFO);

  // Transmit data selection
  always_comb begin
    tx_data_o = 8'h00;
    unique case (state)
      BMSC_SEND_ACK:  tx_data_o = ack_byte;
      BMSC_SEND_SUM:  tx_data_o = (idx == 7'h00) ? flash_sum_i[15:8]
                                                 : flash_sum_i[7:0];
      BMSC_SEND_INFO: tx_data_o = info_byte;
      default:        tx_data_o = 8'h00;
    endcase
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  property p_mode;
    @(posedge clk_i) disable iff (reset_i)
      rst_q |=> boot_from_rom_o == ~$past(pin_sync);
  endproperty
  a_mode: assert property (p_mode) else $error("mode latch wrong");

  property p_irq;
    @(posedge clk_i) disable iff (reset_i)
      !rst_q |=> irq_disable_o == boot_from_rom_o && $stable(irq_disable_o);
  endproperty
  a_irq: assert property (p_irq) else $error("irq not blocked");

  property p_err;
    @(posedge clk_i) disable iff (reset_i)
      (state == BMSC_WAIT_CMD && rx_valid_i && rx_bad)
      |=> tx_valid_o && tx_data_o[3:0] == 4'h8;
  endproperty
  a_err: assert property (p_err) else $error("error ack wrong");

  property p_skip;
    @(posedge clk_i) disable iff (reset_i)
      (state == BMSC_WAIT_CMD && rx_valid_i && clocked_io_mode_i &&
       rx_error_i && (rx_data_i == CMD_SUM || rx_data_i == CMD_INFO))
      |=> tx_data_o == $past(rx_data_i);
  endproperty
  a_skip: assert property (p_skip) else $error("io mode checked");

  property p_echo;
    @(posedge clk_i) disable iff (reset_i)
      (state == BMSC_WAIT_CMD && rx_valid_i && !rx_bad &&
       rx_data_i == CMD_INFO) |=> tx_data_o == CMD_INFO;
  endproperty
  a_echo: assert property (p_echo) else $error("no echo");

  property p_bad;
    @(posedge clk_i) disable iff (reset_i)
      (state == BMSC_WAIT_CMD && rx_valid_i && !rx_bad &&
       rx_data_i != CMD_SUM && rx_data_i != CMD_INFO)
      |=> tx_data_o[3:0] == 4'h1 ##0 tx_data_o[7:4] == $past(prev_hi);
  endproperty
  a_bad: assert property (p_bad) else $error("bad ack wrong");

  property p_sum;
    @(posedge clk_i) disable iff (reset_i)
      (state == BMSC_SEND_SUM && idx == 7'h00)
      |-> tx_data_o == flash_sum_i[15:8];
  endproperty
  a_sum: assert property (p_sum) else $error("sum order");

  property p_id;
    @(posedge clk_i) disable iff (reset_i)
      (state == BMSC_SEND_INFO && idx == 7'h00)
      |-> tx_data_o == sw_id_i[31:24];
  endproperty
  a_id: assert property (p_id) else $error("id byte wrong");

  property p_end;
    @(posedge clk_i) disable iff (reset_i)
      (state == BMSC_SEND_INFO && tx_fire && idx == 7'(INFO_LEN))
      |=> state == BMSC_WAIT_CMD;
  endproperty
  a_end: assert property (p_end) else $error("no return");

  property p_rxhi;
    @(posedge clk_i) disable iff (reset_i)
      (state == BMSC_WAIT_CMD && rx_valid_i && rx_bad)
      |=> tx_data_o[7:4] == $past(prev_hi);
  endproperty
  a_rxhi: assert property (p_rxhi) else $error("error ack nibble");

  property p_rxsum;
    @(posedge clk_i) disable iff (reset_i)
      (state == BMSC_WAIT_CSUM && rx_valid_i)
      |=> csum_bad_o == ($past(rx_data_i) !=
          8'(8'h00 - flash_sum_i[15:8] - flash_sum_i[7:0]));
  endproperty
  a_rxsum: assert property (p_rxsum) else $error("host csum flag");

  property p_csum_wait;
    @(posedge clk_i) disable iff (reset_i)
      (state == BMSC_WAIT_CSUM && rx_valid_i)
      |=> state == BMSC_WAIT_CMD && !tx_valid_o;
  endproperty
  a_csum_wait: assert property (p_csum_wait) else $error("no wait");

  property p_sumlo;
    @(posedge clk_i) disable iff (reset_i)
      (state == BMSC_SEND_SUM && idx == 7'h01)
      |-> tx_data_o == flash_sum_i[7:0];
  endproperty
  a_sumlo: assert property (p_sumlo) else $error("sum low byte");

  property p_cnt;
    @(posedge clk_i) disable iff (reset_i)
      (state == BMSC_SEND_INFO && idx == 7'(INFO_CNT_POS))
      |-> tx_data_o == BLK_COUNT_LO;
  endproperty
  a_cnt: assert property (p_cnt) else $error("block count");

  property p_sum_go;
    @(posedge clk_i) disable iff (reset_i)
      (state == BMSC_SEND_ACK && tx_fire && cmd == CMD_SUM)
      |=> state == BMSC_SEND_SUM && idx == IDX_RST;
  endproperty
  a_sum_go: assert property (p_sum_go) else $error("no sum routine");

endmodule

// ===== bmsc_pkg.sv
package bmsc_pkg;

  // ==========================================================
  // Command codes
  // ==========================================================
  localparam logic [7:0] CMD_SUM  = 8'h20; // Flash sum report
  localparam logic [7:0] CMD_INFO = 8'h30; // Product information

  // ==========================================================
  // Acknowledge error bits
  // ==========================================================
  localparam int         ACK_RXERR_BIT = 3; // Receive error flag
  localparam int         ACK_BADCMD_BIT = 0; // Unknown command flag
  localparam logic [3:0] PREV_CMD_RST = 4'h0; // Upper nibble after reset

  // ==========================================================
  // Response lengths and positions (bytes sent after the ack)
  // ==========================================================
  localparam int         INFO_LEN      = 88; // Bytes five to ninety-two
  localparam int         INFO_ID_LEN   = 4;  // Software identifier bytes
  localparam int         INFO_CNT_POS  = 4;  // Block count position
  localparam int         INFO_GRP_POS  = 52; // Byte 57 relative to byte 5
  localparam int         INFO_GRP_LEN  = 9;  // Bytes per block group
  localparam int         INFO_GRP_NUM  = 4;  // Number of groups
  localparam logic [7:0] BLK_COUNT_LO  = 8'h06; // Flash block count
  localparam logic [7:0] BLK_COUNT_HI  = 8'h00;
  localparam logic [6:0] IDX_RST       = 7'h00;

  // ==========================================================
  // Handler states
  // ==========================================================
  typedef enum logic [2:0] {
    BMSC_WAIT_CMD  = 3'b000,
    BMSC_SEND_ACK  = 3'b001,
    BMSC_SEND_SUM  = 3'b010,
    BMSC_WAIT_CSUM = 3'b011,
    BMSC_SEND_INFO = 3'b100
  } bmsc_state_t;

endpackage

// ===== bmsc_host.sv
`timescale 1ns/1ps
// ==========================================================
// Host controller model: takes device bytes, stalls at random
// ==========================================================
module bmsc_host (
  // Clock
  input  wire logic       clk_i,
  // Device transmit stream
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_data_i,
  output logic            tx_ready_o
);
  logic [7:0]  got_q [$];             // Bytes taken, oldest first
  logic [15:0] stall_lfsr = 16'h1234; // Stall pattern source
  // Ready moves off the sampling edge; about one cycle in four stalls
  always @(negedge clk_i) begin
    stall_lfsr <= {stall_lfsr[14:0], stall_lfsr[15] ^ stall_lfsr[13]
                   ^ stall_lfsr[12] ^ stall_lfsr[10]};
  end
  assign tx_ready_o = stall_lfsr[0] | stall_lfsr[3];
  // Byte taken where valid meets ready, kept in arrival order
  always @(posedge clk_i) begin
    if (tx_valid_i && tx_ready_o) begin
      got_q.push_back(tx_data_i);
    end
  end
endmodule

// ===== bmsc_handler_test.sv
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench for the boot command handler
// ==========================================================
module bmsc_handler_test;
  import bmsc_pkg::*;
  logic        clk_i = 0, reset_i = 1, pin = 0, cio = 0;
  logic        rx_valid = 0, rx_err = 0, tx_valid, tx_ready;
  logic        rom, irq_off, csum_bad;
  logic [7:0]  rx_data = 0, tx_data, b;
  logic [15:0] sum_in = 0, seed = 16'd5759;
  logic [31:0] sw_id = 0;
  logic [71:0] grp [INFO_GRP_NUM];
  int          err_total = 0, check_count = 0;
  always #12.5 clk_i = ~clk_i; // 40 MHz
  bmsc_handler dut_u (.clk_i(clk_i), .reset_i(reset_i),
    .port_h_bit_zero_i(pin), .boot_from_rom_o(rom), .irq_disable_o(irq_off),
    .rx_valid_i(rx_valid), .rx_data_i(rx_data), .rx_error_i(rx_err),
    .clocked_io_mode_i(cio), .tx_valid_o(tx_valid), .tx_data_o(tx_data),
    .tx_ready_i(tx_ready), .flash_sum_i(sum_in), .sw_id_i(sw_id),
    .grp_info_i(grp), .csum_bad_o(csum_bad));
  bmsc_host host_u (.clk_i(clk_i), .tx_valid_i(tx_valid),
    .tx_data_i(tx_data), .tx_ready_o(tx_ready));
  // ==========================================================
  // Helpers
  // ==========================================================
  // Random source
  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction
  // Expected info byte at offset i after the ack
  function automatic logic [7:0] info_byte(int i);
    if (i < 4) return sw_id[31-8*i -: 8];
    if (i == 4) return 8'h06;
    if (i < 52) return 8'h00;
    return grp[(i-52)/9][71-8*((i-52)%9) -: 8];
  endfunction
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One received byte, after the handler has settled back
  task automatic send(input logic [7:0] d, input logic e);
    repeat (3) @(negedge clk_i);
    rx_valid = 1;
    rx_data = d;
    rx_err = e;
    @(negedge clk_i);
    rx_valid = 0;
    rx_err = 0;
    rx_data = ~d;
  endtask
  // Next byte from the host model, bounded wait
  task automatic expect_byte(input string nm, input logic [7:0] e);
    int n;
    n = 0;
    while (host_u.got_q.size() == 0 && n < 300) begin
      @(negedge clk_i);
      n++;
    end
    if (host_u.got_q.size() == 0) begin
      err_total++;
      $display("MISMATCH %s expected %h seen none", nm, e);
      wrap_up();
    end else begin
      b = host_u.got_q.pop_front();
      chk(nm, e, b);
    end
  endtask
  // Sum exchange, host checksum right or broken
  task automatic do_sum(input logic [15:0] s, input logic bad);
    logic [7:0] ck;
    @(negedge clk_i);
    sum_in = s;
    send(CMD_SUM, 1'b0);
    expect_byte("sum ack", 8'h20);
    expect_byte("sum hi", s[15:8]);
    expect_byte("sum lo", s[7:0]);
    ck = 8'h00 - (s[15:8] + s[7:0]);
    send(bad ? ck ^ 8'h01 : ck, 1'b0);
    repeat (2) @(negedge clk_i);
    chk("csum flag", {7'h00, bad}, {7'h00, csum_bad});
  endtask
  // Info exchange with full expected stream and checksum
  task automatic do_info(input logic e);
    logic [7:0] acc;
    acc = 8'h00;
    send(CMD_INFO, e);
    expect_byte("info ack", 8'h30);
    for (int i = 0; i < 88; i++) begin
      expect_byte("info data", info_byte(i));
      acc = acc + info_byte(i);
    end
    expect_byte("info csum", 8'h00 - acc);
  endtask
  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    foreach (grp[k]) grp[k] = 72'({rnd(), rnd(), rnd(), rnd(), rnd()});
    sw_id = {rnd(), rnd()};
    repeat (16) @(negedge clk_i);
    reset_i = 0;
    repeat (2) @(negedge clk_i);
    pin = 1;
    repeat (2) @(negedge clk_i);
    chk("rom mode", 8'h01, {7'h00, rom});
    chk("irq off", 8'h01, {7'h00, irq_off});
    for (int i = 0; i < 3; i++) begin
      do_sum(rnd(), i == 1);
      b = 8'(rnd());
      if (b == CMD_SUM || b == CMD_INFO) b = b ^ 8'h01;
      send(b, 1'b0);
      expect_byte("bad cmd ack", 8'h21);
    end
    do_info(1'b0);
    send(CMD_SUM, 1'b1);
    expect_byte("rx err ack", 8'h38);
    do_sum(16'hffff, 1'b0);
    cio = 1;
    do_info(1'b1);
    cio = 0;
    reset_i = 1;
    repeat (16) @(negedge clk_i);
    reset_i = 0;
    repeat (2) @(negedge clk_i);
    pin = 0;
    repeat (2) @(negedge clk_i);
    chk("flash mode", 8'h00, {7'h00, rom});
    do_sum(16'h0000, 1'b0);
    wrap_up();
  end
endmodule
